// file: rtl/cpfs_pkg.sv
/*
  Package for the clock pin function select block: register offsets, field
  positions, reset values and pin function codes.
  Assumes a single 25 MHz clock domain and a configuration byte port.
*/
package cpfs_pkg;
  localparam logic [7:0] CPFS_OFS_OUT_CTRL = 8'h04;
  localparam logic [7:0] CPFS_OFS_REQ_CFG = 8'h05;
  localparam int CPFS_BIT_P3_DISABLE = 7;
  localparam int CPFS_BIT_C_EN = 3;
  localparam int CPFS_BIT_C_SEL = 2;
  localparam int CPFS_BIT_D_EN = 1;
  localparam int CPFS_BIT_D_SEL = 0;
  localparam logic [7:0] CPFS_RST_OUT_CTRL = 8'h00;
  localparam logic [7:0] CPFS_RST_REQ_CFG = 8'h00;
  localparam int CPFS_NUM_PAIRS = 5;

  // Function carried by the pair-zero pins.
  typedef enum logic {CPFS_P0_SERIAL_REF, CPFS_P0_DISPLAY_96} cpfs_p0_fn_e;
  // Function carried by the two single-ended pins.
  typedef enum logic {CPFS_SE_27MHZ, CPFS_SE_PANEL_100} cpfs_se_fn_e;
endpackage

// file: rtl/cpfs_req_if.sv
/*
  Interface carrying one clock-request route from the top to the router.
  Assumes both modules share i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface cpfs_req_if;
  logic pin_enable;
  logic pair_select;
  logic request_n;
  logic [cpfs_pkg::CPFS_NUM_PAIRS-1:0] stop_mask;
  modport cfg (output pin_enable, output pair_select, output request_n, input stop_mask);
  modport rtr (input pin_enable, input pair_select, input request_n, output stop_mask);
endinterface
`default_nettype wire

// file: rtl/cpfs_req_router.sv
/*
  Routes the two active-low clock-request inputs to the pairs they govern.
  Assumes the configuration and pin levels are synchronous to the caller's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cpfs_req_router (
  // Request C route
  cpfs_req_if.rtr req_c,
  // Request D route
  cpfs_req_if.rtr req_d
);
  import cpfs_pkg::*;

  always_comb begin
    req_c.stop_mask = '0;
    req_d.stop_mask = '0;
    // A high request level means the agent does not want its clock.
    if (req_c.pin_enable && req_c.request_n) begin
      if (req_c.pair_select) begin
        req_c.stop_mask[2] = 1'b1;
      end else begin
        req_c.stop_mask[0] = 1'b1;
      end
    end
    if (req_d.pin_enable && req_d.request_n) begin
      if (req_d.pair_select) begin
        req_d.stop_mask[4] = 1'b1;
      end else begin
        req_d.stop_mask[1] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/cpfs_top.sv
/*
  Pin function selection for the clock generator: strap-chosen pair-zero and
  single-ended pin functions, and the pair-three pins as clock-request inputs.
  Assumes a byte-wide configuration write port and a strap valid at reset.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Pair-zero complement pin: serial ref pair zero if strap is high, display 96 MHz if low.
// - First single-ended pin: 27 MHz non-spread if strap is high, panel clock true side if low.
// - Second single-ended pin: 27 MHz spread if strap is high, panel clock complement if low.
// - Pair-three pins start as clock outputs and change only by configuration writes.
// - Byte 5 bit 3 turns the pair-three true pin into request input C.
// - Byte 5 bit 2 routes request C to pair zero (0) or pair two (1).
// - Byte 5 bit 1 turns the pair-three complement pin into request input D.
// - Byte 5 bit 0 routes request D to pair one (0) or pair four (1).
// - The strap picks the pair-zero true pin function the same way as the complement pin.
module cpfs_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Strap
  input wire logic i_freq_strap,
  // Configuration byte port
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  // Pair-three pin levels when used as requests
  input wire logic i_clock_request_in_c_n,
  input wire logic i_clock_request_in_d_n,
  // Pin functions
  output logic o_p0_true_display_96,
  output logic o_p0_comp_display_96,
  output logic o_se1_panel_clock_true,
  output logic o_se2_panel_clock_comp,
  output logic o_pair_three_true_out_en,
  output logic o_pair_three_comp_out_en,
  output logic o_request_c_pin_enable,
  output logic o_request_d_pin_enable,
  output logic [cpfs_pkg::CPFS_NUM_PAIRS-1:0] o_pair_stop
);
  import cpfs_pkg::*;

  logic strap_ff, nxt_strap;
  logic armed_ff, nxt_armed;
  logic [7:0] out_ctrl_ff, nxt_out_ctrl;
  logic [7:0] req_cfg_ff, nxt_req_cfg;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [CPFS_NUM_PAIRS-1:0] stop_ff, nxt_stop;
  cpfs_p0_fn_e p0_fn;
  cpfs_se_fn_e se_fn;

  cpfs_req_if req_c ();
  cpfs_req_if req_d ();

  assign req_c.pin_enable = req_cfg_ff[CPFS_BIT_C_EN];
  assign req_c.pair_select = req_cfg_ff[CPFS_BIT_C_SEL];
  assign req_c.request_n = i_clock_request_in_c_n;
  assign req_d.pin_enable = req_cfg_ff[CPFS_BIT_D_EN];
  assign req_d.pair_select = req_cfg_ff[CPFS_BIT_D_SEL];
  assign req_d.request_n = i_clock_request_in_d_n;

  cpfs_req_router u_router (
    .req_c(req_c),
    .req_d(req_d)
  );

  // The strap is caught on the first clocked cycle after reset, then frozen.
  always_comb begin
    nxt_armed = 1'b1;
    nxt_strap = armed_ff ? strap_ff : i_freq_strap;
  end

  always_comb begin
    nxt_out_ctrl = out_ctrl_ff;
    nxt_req_cfg = req_cfg_ff;
    if (i_cfg_wr && i_cfg_addr == CPFS_OFS_OUT_CTRL) begin
      nxt_out_ctrl = i_cfg_wdata;
    end
    if (i_cfg_wr && i_cfg_addr == CPFS_OFS_REQ_CFG) begin
      nxt_req_cfg = i_cfg_wdata;
    end
    unique case (i_cfg_addr)
      CPFS_OFS_OUT_CTRL: nxt_rdata = out_ctrl_ff;
      CPFS_OFS_REQ_CFG: nxt_rdata = req_cfg_ff;
      default: nxt_rdata = 8'h00;
    endcase
    nxt_stop = req_c.stop_mask | req_d.stop_mask;
  end

  assign p0_fn = strap_ff ? CPFS_P0_SERIAL_REF : CPFS_P0_DISPLAY_96;
  assign se_fn = strap_ff ? CPFS_SE_27MHZ : CPFS_SE_PANEL_100;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      armed_ff <= 1'b0;
      strap_ff <= 1'b1;
      out_ctrl_ff <= CPFS_RST_OUT_CTRL;
      req_cfg_ff <= CPFS_RST_REQ_CFG;
      rdata_ff <= 8'h00;
      stop_ff <= '0;
      o_p0_true_display_96 <= 1'b0;
      o_p0_comp_display_96 <= 1'b0;
      o_se1_panel_clock_true <= 1'b0;
      o_se2_panel_clock_comp <= 1'b0;
      o_pair_three_true_out_en <= 1'b1;
      o_pair_three_comp_out_en <= 1'b1;
      o_request_c_pin_enable <= 1'b0;
      o_request_d_pin_enable <= 1'b0;
    end else begin
      armed_ff <= nxt_armed;
      strap_ff <= nxt_strap;
      out_ctrl_ff <= nxt_out_ctrl;
      req_cfg_ff <= nxt_req_cfg;
      rdata_ff <= nxt_rdata;
      stop_ff <= nxt_stop;
      o_p0_true_display_96 <= (p0_fn == CPFS_P0_DISPLAY_96);
      o_p0_comp_display_96 <= (p0_fn == CPFS_P0_DISPLAY_96);
      o_se1_panel_clock_true <= (se_fn == CPFS_SE_PANEL_100);
      o_se2_panel_clock_comp <= (se_fn == CPFS_SE_PANEL_100);
      // A pin drives the pair only while not a request input and not disabled.
      o_pair_three_true_out_en <= !out_ctrl_ff[CPFS_BIT_P3_DISABLE] &&
                                  !req_cfg_ff[CPFS_BIT_C_EN];
      o_pair_three_comp_out_en <= !out_ctrl_ff[CPFS_BIT_P3_DISABLE] &&
                                  !req_cfg_ff[CPFS_BIT_D_EN];
      o_request_c_pin_enable <= req_cfg_ff[CPFS_BIT_C_EN];
      o_request_d_pin_enable <= req_cfg_ff[CPFS_BIT_D_EN];
    end
  end

  assign o_cfg_rdata = rdata_ff;
  assign o_pair_stop = stop_ff;

  // Checks.
  property p_strap_frozen;
    @(posedge i_clk) disable iff (i_srst) $past(armed_ff) |-> $stable(strap_ff);
  endproperty
  a_strap_frozen: assert property (p_strap_frozen) else $error("strap not frozen");

  property p_p0_comp;
    @(posedge i_clk) disable iff (i_srst)
      armed_ff ##1 1'b1 |-> o_p0_comp_display_96 == !$past(strap_ff);
  endproperty
  a_p0_comp: assert property (p_p0_comp) else $error("pair zero complement function wrong");

  property p_p0_true;
    @(posedge i_clk) disable iff (i_srst) o_p0_true_display_96 == o_p0_comp_display_96;
  endproperty
  a_p0_true: assert property (p_p0_true) else $error("pair zero pins disagree");

  property p_se1;
    @(posedge i_clk) disable iff (i_srst)
      armed_ff ##1 1'b1 |-> o_se1_panel_clock_true == !$past(strap_ff);
  endproperty
  a_se1: assert property (p_se1) else $error("first single-ended function wrong");

  property p_se2;
    @(posedge i_clk) disable iff (i_srst) o_se2_panel_clock_comp == o_se1_panel_clock_true;
  endproperty
  a_se2: assert property (p_se2) else $error("second single-ended function wrong");

  property p_c_enable;
    @(posedge i_clk) disable iff (i_srst)
      i_cfg_wr && i_cfg_addr == CPFS_OFS_REQ_CFG ##1 !i_cfg_wr |=>
        o_request_c_pin_enable == $past(i_cfg_wdata[CPFS_BIT_C_EN], 2);
  endproperty
  a_c_enable: assert property (p_c_enable) else $error("request C enable not applied");

  property p_d_enable;
    @(posedge i_clk) disable iff (i_srst)
      o_request_d_pin_enable |-> !o_pair_three_comp_out_en;
  endproperty
  a_d_enable: assert property (p_d_enable) else $error("pin D drives while a request");

  property p_c_route;
    @(posedge i_clk) disable iff (i_srst)
      req_cfg_ff[CPFS_BIT_C_EN] && !req_cfg_ff[CPFS_BIT_D_EN] && i_clock_request_in_c_n |=>
        o_pair_stop[0] == !$past(req_cfg_ff[CPFS_BIT_C_SEL]) &&
        o_pair_stop[2] == $past(req_cfg_ff[CPFS_BIT_C_SEL]);
  endproperty
  a_c_route: assert property (p_c_route) else $error("request C routed wrong");

  property p_d_route;
    @(posedge i_clk) disable iff (i_srst)
      req_cfg_ff[CPFS_BIT_D_EN] && !req_cfg_ff[CPFS_BIT_C_EN] && i_clock_request_in_d_n |=>
        o_pair_stop[1] == !$past(req_cfg_ff[CPFS_BIT_D_SEL]) &&
        o_pair_stop[4] == $past(req_cfg_ff[CPFS_BIT_D_SEL]);
  endproperty
  a_d_route: assert property (p_d_route) else $error("request D routed wrong");

  property p_p3_default;
    @(posedge i_clk) disable iff (i_srst)
      $rose(armed_ff) |-> o_pair_three_true_out_en && o_pair_three_comp_out_en;
  endproperty
  a_p3_default: assert property (p_p3_default) else $error("pair three not output");

  c_c_enabled: cover property (@(posedge i_clk) disable iff (i_srst) o_request_c_pin_enable);
  c_d_pair4: cover property (@(posedge i_clk) disable iff (i_srst) o_pair_stop[4]);
  c_strap_low: cover property (@(posedge i_clk) disable iff (i_srst) o_se1_panel_clock_true);
endmodule
`default_nettype wire

// file: testbench/cpfs_agent_model.sv
/*
  Model of the chipset agents that drive the two clock-request pins.
  Assumes the bench commands the pin levels; the pins change just after the clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cpfs_agent_model (
  // Clock
  input wire logic i_clk,
  // Commanded levels, high means the agent wants its pair stopped
  input wire logic i_lvl_c,
  input wire logic i_lvl_d,
  // Request pins, active low
  output logic o_req_c_n,
  output logic o_req_d_n
);
  initial begin
    o_req_c_n = 1'b0;
    o_req_d_n = 1'b0;
  end
  // Levels move only after an edge, so the block never samples them mid-change.
  always @(posedge i_clk) begin
    o_req_c_n <= #1 i_lvl_c;
    o_req_d_n <= #1 i_lvl_d;
  end
endmodule
`default_nettype wire

// file: testbench/cpfs_tb_top.sv
/*
  Self-checking bench for the clock pin function select block.
  Assumes the block's package and the agent model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module cpfs_tb_top;
  import cpfs_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic strap = 1'b1;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic lvl_c = 1'b0;
  logic lvl_d = 1'b0;
  logic req_c_n, req_d_n, p0t, p0c, se1, se2, p3t, p3c, ren_c, ren_d;
  logic sample = 1'b0;
  logic [CPFS_NUM_PAIRS-1:0] stop;
  logic [20:0] seen_vec;
  logic [20:0] notes[$];
  logic [31:0] rng = 32'h4132F610;
  logic [7:0] b5;
  int fails = 0;
  int check_count = 0;

  cpfs_top dut (.i_clk(clk), .i_srst(srst), .i_freq_strap(strap), .i_cfg_wr(wr),
    .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
    .i_clock_request_in_c_n(req_c_n), .i_clock_request_in_d_n(req_d_n),
    .o_p0_true_display_96(p0t), .o_p0_comp_display_96(p0c), .o_se1_panel_clock_true(se1),
    .o_se2_panel_clock_comp(se2), .o_pair_three_true_out_en(p3t),
    .o_pair_three_comp_out_en(p3c), .o_request_c_pin_enable(ren_c),
    .o_request_d_pin_enable(ren_d), .o_pair_stop(stop));
  cpfs_agent_model agents (.i_clk(clk), .i_lvl_c(lvl_c), .i_lvl_d(lvl_d),
    .o_req_c_n(req_c_n), .o_req_d_n(req_d_n));

  initial forever #20 clk = ~clk;

  assign seen_vec = {rdata, p0t, p0c, se1, se2, p3t, p3c, ren_c, ren_d, stop};

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Expected outputs: read data, strap functions, pin roles and the stop mask.
  function automatic logic [20:0] expect_of(logic s, logic [7:0] b4, logic [7:0] cfg,
                                            logic cn, logic dn, logic [7:0] rd);
    logic [4:0] st;
    st = 5'h00;
    if (cfg[3] && cn) st[cfg[2] ? 2 : 0] = 1'b1;
    if (cfg[1] && dn) st[cfg[0] ? 4 : 1] = 1'b1;
    return {rd, ~s, ~s, ~s, ~s, ~b4[7] & ~cfg[3], ~b4[7] & ~cfg[1], cfg[3], cfg[1], st};
  endfunction

  task automatic check(string name, logic [20:0] exp, logic [20:0] seen);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr8(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask

  // Lets the pins, the stop mask and the read path settle, then files the note.
  task automatic look(logic [20:0] exp, logic [7:0] ra);
    addr = ra;
    repeat (4) @(posedge clk);
    #1;
    notes.push_back(exp);
    sample = 1'b1;
    @(posedge clk);
    #1;
    sample = 1'b0;
  endtask

  task automatic boot(logic s);
    srst = 1'b1;
    strap = s;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    strap = ~s;
  endtask

  // Outputs are read at the falling edge, well clear of the edge that launches them.
  always @(negedge clk) begin
    if (sample === 1'b1 && notes.size() > 0) begin
      check("outputs", notes.pop_front(), seen_vec);
    end
  end

  initial begin
    #(4000 * 40);
    fails++;
    conclude();
  end

  initial begin
    for (int s = 0; s < 2; s++) begin
      boot(s[0]);
      lvl_c = 1'b1;
      lvl_d = 1'b1;
      look(expect_of(s[0], 8'h00, 8'h00, 1'b1, 1'b1, 8'h00), CPFS_OFS_REQ_CFG);
      wr8(8'h06, 8'hFF);
      look(expect_of(s[0], 8'h00, 8'h00, 1'b1, 1'b1, 8'h00), 8'h06);
      wr8(CPFS_OFS_OUT_CTRL, 8'h80);
      look(expect_of(s[0], 8'h80, 8'h00, 1'b1, 1'b1, 8'h80), CPFS_OFS_OUT_CTRL);
      for (int i = 0; i < 20; i++) begin
        rng = xs(rng);
        b5 = rng[7:0];
        lvl_c = rng[8];
        lvl_d = rng[9];
        wr8(CPFS_OFS_REQ_CFG, b5);
        look(expect_of(s[0], 8'h80, b5, rng[8], rng[9], b5), CPFS_OFS_REQ_CFG);
      end
    end
    conclude();
  end
endmodule
`default_nettype wire
